// [design/rhbs_pkg.sv]
package rhbs_pkg;

  // Operating modes of the sequencer.
  typedef enum logic [1:0] {
    RHBS_LOCKOUT = 2'b00,
    RHBS_SLEEP   = 2'b01,
    RHBS_NORMAL  = 2'b10,
    RHBS_FAULT   = 2'b11
  } rhbs_mode_t;

  // Oscillator ramp phases in normal mode.
  typedef enum logic [1:0] {
    RHBS_BOOT = 2'b00,
    RHBS_RISE = 2'b01,
    RHBS_FALL = 2'b10
  } rhbs_ramp_t;

  localparam int          CLK_HZ          = 20000000;
  localparam int          MASK_TIME_NS    = 300;
  localparam int          MASK_CYCLES     =
    (MASK_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam logic [3:0]  MASK_CNT_W      = 4'h4;
  localparam logic        FIRST_TOP_Q_RST = 1'b0;
  localparam int          OCP_TRIP_LOW_MV  = 2000;
  localparam int          OCP_TRIP_HIGH_MV = 3000;
  localparam int          RAMP_LOW_MV     = 3000;
  localparam int          RAMP_HIGH_MV    = 5000;
  localparam int          FSW_MIN_KHZ     = 50;
  localparam int          FSW_MAX_KHZ     = 500;
  localparam int          START_CURRENT_UA = 10;
  localparam int          DISCH_CURRENT_MA = 2;

endpackage : rhbs_pkg

// [design/rhbs_blank_if.sv]
`timescale 1ns/1ps
interface rhbs_blank_if;
  logic arm;
  logic done;
  modport ctrl (output arm, input done);
  modport timer (input arm, output done);
endinterface : rhbs_blank_if

// [design/rhbs_blank_timer.sv]
`timescale 1ns/1ps
module rhbs_blank_timer
  import rhbs_pkg::*;
#(
  parameter int MASK_CYC = MASK_CYCLES
) (
  input  wire logic   clk_in,
  input  wire logic   resetn_in,
  rhbs_blank_if.timer bl
);
  logic [7:0] cnt_q;

  // Counts from the low-side rising edge; done holds until arm drops.
  always_ff @(posedge clk_in) begin
    if (!resetn_in || !bl.arm) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != MASK_CYC[7:0]) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign bl.done = bl.arm && (cnt_q == MASK_CYC[7:0]);
endmodule : rhbs_blank_timer

// [design/rhbs_sequencer.sv]
`timescale 1ns/1ps
// Contract
// - Lockout with drives off until supply valid.
// - Supply drop returns to lockout from anywhere.
// - Bottom drive held low in lockout.
// - Sleep charges timing cap, drives off; code charges only while cap_below_sleep_in is low.
// - Enable threshold exits sleep, enables reference.
// - Pulling pin low enters sleep, discharges resistor.
// - Drives alternate, equal on time.
// - Dead time equals ramp fall time.
// - Ramp swings between lower and upper thresholds.
// - Upper threshold starts fixed-current discharge.
// - Frequency rises with sourced current.
// - Low side first after start or sleep.
// - First low pulse lasts until upper threshold.
// - Overcurrent check only in normal mode.
// - Sample sense after mask time on low.
// - Trip ends pulse, stops all, faults.
// - Fault discharges timing pins, stays latched.
// - Trip level fixed per variant.
// - Soft start at start-up and sleep exit; the code has no soft-start logic.
// - Output frequency range fifty to five hundred.
// - Mask time about three hundred nanoseconds.
// - Fault clears only by supply cycling.
module rhbs_sequencer
  import rhbs_pkg::*;
#(
  parameter bit LOW_TRIP_VARIANT = 1'b0
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic supply_above_on_in,
  input  wire logic supply_below_off_in,
  input  wire logic cap_above_enable_in,
  input  wire logic cap_below_sleep_in,
  input  wire logic ramp_at_upper_in,
  input  wire logic ramp_at_lower_in,
  input  wire logic sense_over_trip_in,
  output logic      top_switch_drive_out,
  output logic      bottom_switch_drive_out,
  output logic      bottom_pulldown_out,
  output logic      cap_startup_charge_out,
  output logic      cap_charge_out,
  output logic      cap_discharge_out,
  output logic      cap_dump_out,
  output logic      resistor_ref_enable_out,
  output logic      resistor_discharge_out,
  output logic      trip_level_high_out,
  output logic      fault_latched_out,
  output logic [1:0] mode_out
);

  rhbs_mode_t mode_q;
  rhbs_mode_t mode_d;
  rhbs_ramp_t ramp_q;
  rhbs_ramp_t ramp_d;
  logic       next_top_q;
  logic       top_q;
  logic       bot_q;
  logic       trip;
  logic       fault_q;

  rhbs_blank_if bl ();

  // Leading-edge mask runs while the bottom drive is on.
  rhbs_blank_timer #(
    .MASK_CYC (MASK_CYCLES)
  ) u_blank (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .bl        (bl)
  );
  assign bl.arm = bot_q;

  // Trip only counts once masked, in normal mode, with low side on.
  // The comparator already encodes the variant level.
  assign trip = (mode_q == RHBS_NORMAL) && bot_q && bl.done &&
                sense_over_trip_in;

  // Mode transitions; supply loss outranks everything.
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      RHBS_LOCKOUT: begin
        if (supply_above_on_in && !supply_below_off_in) begin
          mode_d = RHBS_SLEEP;
        end
      end
      RHBS_SLEEP: begin
        if (cap_above_enable_in && !cap_below_sleep_in) begin
          mode_d = RHBS_NORMAL;
        end
      end
      RHBS_NORMAL: begin
        if (trip) begin
          mode_d = RHBS_FAULT;
        end else if (cap_below_sleep_in) begin
          mode_d = RHBS_SLEEP;
        end
      end
      RHBS_FAULT: begin
        mode_d = RHBS_FAULT;
      end
      default: begin
        mode_d = RHBS_LOCKOUT;
      end
    endcase
    if (supply_below_off_in) begin
      mode_d = RHBS_LOCKOUT;
    end
  end

  // Mode register.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      mode_q <= RHBS_LOCKOUT;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Ramp phase: boot pulse first, then rise and fall alternate.
  always_comb begin
    ramp_d = ramp_q;
    if (mode_d != RHBS_NORMAL || mode_q != RHBS_NORMAL) begin
      ramp_d = RHBS_BOOT;
    end else begin
      case (ramp_q)
        RHBS_BOOT: begin
          if (ramp_at_upper_in) begin
            ramp_d = RHBS_FALL;
          end
        end
        RHBS_RISE: begin
          if (ramp_at_upper_in) begin
            ramp_d = RHBS_FALL;
          end
        end
        RHBS_FALL: begin
          if (ramp_at_lower_in) begin
            ramp_d = RHBS_RISE;
          end
        end
        default: begin
          ramp_d = RHBS_BOOT;
        end
      endcase
    end
  end

  // Ramp register and side selection for the next rise.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      ramp_q     <= RHBS_BOOT;
      next_top_q <= FIRST_TOP_Q_RST;
    end else begin
      ramp_q <= ramp_d;
      if (ramp_d == RHBS_BOOT) begin
        next_top_q <= 1'b1;
      end else if (ramp_q == RHBS_FALL && ramp_d == RHBS_RISE) begin
        next_top_q <= ~next_top_q;
      end
    end
  end

  // Drives are on only during the boot pulse or a rise, so each fall is dead time and
  // both sides share the same rise length.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      top_q <= 1'b0;
      bot_q <= 1'b0;
    end else if (mode_d != RHBS_NORMAL) begin
      top_q <= 1'b0;
      bot_q <= 1'b0;
    end else begin
      // Once a rise has begun, next_top_q already names the side after
      // this one, so the side now on is its inverse.
      top_q <= (ramp_d == RHBS_RISE) && !next_top_q &&
               !(ramp_q == RHBS_FALL);
      bot_q <= (ramp_d == RHBS_BOOT) ||
               ((ramp_d == RHBS_RISE) && next_top_q &&
                !(ramp_q == RHBS_FALL));
      // At the start of a rise the side is the one picked for it.
      if (ramp_q == RHBS_FALL && ramp_d == RHBS_RISE) begin
        top_q <= next_top_q;
        bot_q <= !next_top_q;
      end
    end
  end

  // Fault flag follows the latched mode for visibility.
  always_ff @(posedge clk_in) begin
    if (!resetn_in) begin
      fault_q <= 1'b0;
    end else begin
      fault_q <= (mode_d == RHBS_FAULT);
    end
  end

  // Pin controls; frequency follows the external resistor current,
  // so the design only gates the reference.
  assign top_switch_drive_out    = top_q;
  assign bottom_switch_drive_out = bot_q;
  assign bottom_pulldown_out     = (mode_q == RHBS_LOCKOUT);
  assign cap_startup_charge_out  = (mode_q == RHBS_SLEEP) &&
                                   !cap_below_sleep_in;
  assign cap_charge_out          = (mode_q == RHBS_NORMAL) &&
                                   (ramp_q != RHBS_FALL);
  assign cap_discharge_out       = (mode_q == RHBS_NORMAL) &&
                                   (ramp_q == RHBS_FALL);
  assign cap_dump_out            = (mode_q == RHBS_FAULT);
  assign resistor_ref_enable_out = (mode_q == RHBS_NORMAL);
  assign resistor_discharge_out  = (mode_q == RHBS_SLEEP) ||
                                   (mode_q == RHBS_FAULT);
  assign trip_level_high_out     = !LOW_TRIP_VARIANT;
  assign fault_latched_out       = fault_q;
  assign mode_out                = mode_q;

endmodule : rhbs_sequencer

// [test/rhbs_ramp_model.sv]
`timescale 1ns/1ps
// Timing capacitor on the oscillator pins, seen through its comparators.
module rhbs_ramp_model #(
  parameter int RISE_N = 9
) (
  input  wire logic clk_in,
  input  wire logic charge_in,
  input  wire logic discharge_in,
  output logic      upper_out,
  output logic      lower_out
);
  int lvl_q = 0;
  // The fixed sink falls twice as fast as the charge; idle pins sit at ground.
  always_ff @(posedge clk_in) begin
    if (discharge_in) lvl_q <= (lvl_q > 0) ? lvl_q - 2 : lvl_q;
    else if (charge_in) lvl_q <= (lvl_q < RISE_N) ? lvl_q + 1 : lvl_q;
    else lvl_q <= 0;
  end
  assign upper_out = (lvl_q >= RISE_N);
  assign lower_out = (lvl_q <= 0);
endmodule : rhbs_ramp_model

// [test/rhbs_sequencer_chk.sv]
`timescale 1ns/1ps
// Mode and drive relations at the sequencer pins.
module rhbs_sequencer_chk (
  input wire logic       clk_in,
  input wire logic       resetn_in,
  input wire logic       supply_below_off_in,
  input wire logic       cap_above_enable_in,
  input wire logic       cap_below_sleep_in,
  input wire logic       sense_over_trip_in,
  input wire logic       top_switch_drive_out,
  input wire logic       bottom_switch_drive_out,
  input wire logic       bottom_pulldown_out,
  input wire logic       cap_discharge_out,
  input wire logic       cap_dump_out,
  input wire logic       resistor_discharge_out,
  input wire logic [1:0] mode_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  logic [3:0] lo_q;
  // Edges the bottom drive has stood high, so the mask window can be judged.
  always_ff @(posedge clk_in) begin
    if (!bottom_switch_drive_out) lo_q <= 4'h0;
    else if (lo_q != 4'hF) lo_q <= lo_q + 4'h1;
  end
  // Short names keep the properties readable.
  wire logic tp = top_switch_drive_out;
  wire logic bt = bottom_switch_drive_out;
  wire logic uv = supply_below_off_in;
  property p_lock; mode_out == 2'h0 |-> !bt && bottom_pulldown_out; endproperty
  a_lock: assert property (p_lock) else $error("lockout drive");
  property p_idle; mode_out != 2'h2 |-> !tp && !bt; endproperty
  a_idle: assert property (p_idle) else $error("drive outside run");
  property p_uvlo; uv |=> mode_out == 2'h0; endproperty
  a_uvlo: assert property (p_uvlo) else $error("no lockout");
  property p_wake; mode_out == 2'h1 && cap_above_enable_in &&
    !cap_below_sleep_in && !uv |=> mode_out == 2'h2 && bt && !tp; endproperty
  a_wake: assert property (p_wake) else $error("bad wake");
  property p_sleep; mode_out == 2'h2 && cap_below_sleep_in && !uv &&
    !sense_over_trip_in |=> mode_out == 2'h1 && resistor_discharge_out;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");
  property p_dead; cap_discharge_out || tp |-> !bt; endproperty
  a_dead: assert property (p_dead) else $error("drive overlap");
  property p_mask; mode_out == 2'h2 && lo_q < 4'h6 && !cap_below_sleep_in &&
    !uv |=> mode_out == 2'h2; endproperty
  a_mask: assert property (p_mask) else $error("trip in mask");
  property p_trip; mode_out == 2'h2 && bt && lo_q >= 4'h6 && !uv &&
    sense_over_trip_in |=> mode_out == 2'h3 && !bt && !tp; endproperty
  a_trip: assert property (p_trip) else $error("no trip");
  property p_latch; mode_out == 2'h3 && !uv |=> mode_out == 2'h3 &&
    cap_dump_out; endproperty
  a_latch: assert property (p_latch) else $error("fault left");
  c_fault: cover property (mode_out == 2'h3);
  c_top: cover property (mode_out == 2'h2 && tp);
  c_nap: cover property (mode_out == 2'h2 ##1 mode_out == 2'h1);
endmodule : rhbs_sequencer_chk
bind rhbs_sequencer rhbs_sequencer_chk i_chk (.*);

// [test/rhbs_sequencer_tb.sv]
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin err_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, b); end end
module rhbs_sequencer_tb
  import rhbs_pkg::*;
;
  localparam int RISE = 9;
  logic clk_in = 0, resetn_in = 0, supply_above_on_in = 0;
  logic supply_below_off_in = 0, cap_above_enable_in = 0;
  logic cap_below_sleep_in = 0, sense_over_trip_in = 0;
  logic ramp_at_upper_in, ramp_at_lower_in, top_switch_drive_out;
  logic bottom_switch_drive_out, bottom_pulldown_out, cap_charge_out;
  logic cap_startup_charge_out, cap_discharge_out, cap_dump_out;
  logic resistor_ref_enable_out, resistor_discharge_out;
  logic trip_level_high_out, fault_latched_out;
  logic [1:0] mode_out;
  int err_count = 0, checks_done = 0, seed = 38, cyc = 0;
  int t_run = 0, b_run = 0, top_len = 0, bot_len = 0;
  rhbs_sequencer i_dut (.*);
  rhbs_ramp_model #(.RISE_N(RISE)) i_ramp (.clk_in,
    .charge_in(cap_charge_out), .discharge_in(cap_discharge_out),
    .upper_out(ramp_at_upper_in), .lower_out(ramp_at_lower_in));
  initial forever #25 clk_in = ~clk_in;
  // Pulse lengths of both drives, and a guard against a hang.
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 4000) begin err_count++; summarize(); end
    if (top_switch_drive_out === 1'b1) t_run++;
    else if (t_run > 0) begin top_len = t_run; t_run = 0; end
    if (bottom_switch_drive_out === 1'b1) b_run++;
    else if (b_run > 0) begin bot_len = b_run; b_run = 0; end
  end
  task automatic go(input int n);
    repeat (n) @(posedge clk_in);
    #5;
  endtask : go
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize
  // Brings the supply up and wakes the oscillator.
  task automatic power_up;
    cap_above_enable_in = 0;
    supply_below_off_in = 0;
    supply_above_on_in = 1;
    go(2);
    `CHK({mode_out, cap_startup_charge_out}, 3'h3)
    cap_above_enable_in = 1;
    go(1);
    `CHK({mode_out, resistor_ref_enable_out}, 3'h5)
    $display("test power up done");
  endtask : power_up
  // Waits for a fresh rising edge of the bottom drive.
  task automatic bot_rise;
    repeat (50) if (bottom_switch_drive_out !== 1'b0) go(1);
    repeat (50) if (bottom_switch_drive_out !== 1'b1) go(1);
  endtask : bot_rise
  initial begin
    go(3);
    resetn_in = 1;
    go(4);
    `CHK({mode_out, bottom_pulldown_out, trip_level_high_out}, 4'h3)
    power_up();
    repeat (50) if (bottom_switch_drive_out !== 1'b0) go(1);
    go(2);
    `CHK(bot_len >= RISE, 1'b1)
    go(100);
    `CHK(top_len, bot_len)
    `CHK(top_len > 0, 1'b1)
    // A sense spike that ends inside the mask window must be ignored.
    bot_rise();
    sense_over_trip_in = 1;
    go(MASK_CYCLES - 2);
    sense_over_trip_in = 0;
    go(2);
    `CHK(mode_out, RHBS_NORMAL)
    go(5 + $unsigned($random(seed)) % 20);
    cap_below_sleep_in = 1;
    cap_above_enable_in = 0;
    go(1);
    `CHK({mode_out, resistor_discharge_out, top_switch_drive_out}, 4'h6)
    sense_over_trip_in = 1;
    go(3);
    `CHK(mode_out, RHBS_SLEEP)
    sense_over_trip_in = 0;
    cap_below_sleep_in = 0;
    cap_above_enable_in = 1;
    go(1);
    `CHK({mode_out, bottom_switch_drive_out}, 3'h5)
    $display("test sleep done");
    // Sense raised at random points inside the mask, so each trip lands as the mask ends, then supply cycling.
    repeat (3) begin
      bot_rise();
      go($unsigned($random(seed)) % 3);
      sense_over_trip_in = 1;
      repeat (12) if (mode_out !== RHBS_FAULT) go(1);
      `CHK({mode_out, fault_latched_out, bottom_switch_drive_out}, 4'hE)
      sense_over_trip_in = 0;
      cap_above_enable_in = 0;
      go(4);
      cap_above_enable_in = 1;
      go(4);
      `CHK({mode_out, cap_dump_out}, 3'h7)
      supply_below_off_in = 1;
      supply_above_on_in = 0;
      go(1);
      `CHK(mode_out, RHBS_LOCKOUT)
      power_up();
    end
    go(30);
    supply_below_off_in = 1;
    go(1);
    `CHK({mode_out, bottom_pulldown_out, bottom_switch_drive_out}, 4'h2)
    $display("test fault done");
    summarize();
  end
endmodule : rhbs_sequencer_tb
